// file: rtl/ptr_pkg.sv
// shared constants for the protection and trim register bank
package ptr_pkg;
  localparam logic [15:0] ADDR_OV_RISE = 16'hfe2f;
  localparam logic [15:0] ADDR_OV_FALL = 16'hfe30;
  localparam logic [15:0] ADDR_OV_DEB = 16'hfe31;
  localparam logic [15:0] ADDR_LP_ENTRY = 16'hfe32;
  localparam logic [15:0] ADDR_OFS_TRIM = 16'hfe33;
  localparam logic [15:0] ADDR_GAIN_TRIM = 16'hfe34;
  localparam logic [15:0] ADDR_HIGH_LINE = 16'hfe35;
  localparam logic [15:0] ADDR_LOW_LINE = 16'hfe36;
  localparam logic [15:0] ADDR_CURRENT_LIMIT_REFERENCE_ADJ = 16'hfe37;
  localparam logic [15:0] ADDR_VLOOP = 16'hfe38;
  // writable bit masks; reserved bits outside these read as zero
  localparam logic [7:0] MASK_OV_LEVEL = 8'h7f;
  localparam logic [7:0] MASK_OV_DEB = 8'h03;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_CURRENT_LIMIT_REFERENCE_ADJ = 8'h1f;
  localparam int SIGN_BIT = 7;
  localparam int CURRENT_LIMIT_REFERENCE_DIR_BIT = 4;
  localparam logic [7:0] RST_REG = 8'h00;
  // overvoltage level in microvolts: 1 V base, 0.492 V spread over 128 codes
  localparam int OV_BASE_UV = 1000000;
  localparam int OV_SPAN_UV = 492000;
  localparam int OV_CODES = 128;
  localparam int CURRENT_LIMIT_REFERENCE_DIV_LOG2 = 6;
  localparam int TRIM_DIV_LOG2 = 11;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DEB_NS_0 = 120;
  localparam int DEB_NS_1 = 240;
  localparam int DEB_NS_2 = 480;
  localparam int DEB_NS_3 = 640;
  // least times round up to whole cycles
  localparam int DEB_CYC_0 = (DEB_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_CYC_1 = (DEB_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_CYC_2 = (DEB_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_CYC_3 = (DEB_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic {PTR_LOW_SET, PTR_HIGH_SET} ptr_coef_e;
endpackage

// file: rtl/ptr_debounce.sv
// overvoltage comparator debounce with selectable hold time
`timescale 1ns/10ps
module ptr_debounce
  import ptr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] sel,
  input wire logic raw,
  output logic level
);
  logic [5:0] cnt;
  logic [5:0] limit;

  always_comb
  begin
    case (sel)
      2'h0: limit = 6'(DEB_CYC_0);
      2'h1: limit = 6'(DEB_CYC_1);
      2'h2: limit = 6'(DEB_CYC_2);
      default: limit = 6'(DEB_CYC_3);
    endcase
  end

  // output follows the input only once it has stood unchanged for the hold time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 6'h00;
      level <= 1'b0;
    end
    else if (raw == level)
      cnt <= 6'h00;
    else if (cnt + 6'h01 >= limit)
    begin
      cnt <= 6'h00;
      level <= raw;
    end
    else
      cnt <= cnt + 6'h01;
  end
endmodule

// file: rtl/ptr_trim.sv
// signed proportional trim: base plus or minus base*mag/2^shift
`timescale 1ns/10ps
module ptr_trim #(
  parameter int W = 16,
  parameter int MAG_W = 7,
  parameter int SHIFT = 11
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] base,
  input wire logic negative,
  input wire logic [MAG_W-1:0] mag,
  output logic [W-1:0] result
);
  logic [W+MAG_W-1:0] prod;
  logic [W-1:0] delta;
  logic [W:0] sum;

  always_comb
  begin
    prod = base * mag;
    delta = W'(prod >> SHIFT);
    if (negative)
      sum = (base >= delta) ? {1'b0, base - delta} : '0;
    else
      sum = {1'b0, base} + {1'b0, delta};
  end

  // saturate on overflow rather than wrap
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      result <= '0;
    else
      result <= sum[W] ? {W{1'b1}} : sum[W-1:0];
  end
endmodule

// file: rtl/ptr_regs.sv
// protection and trim register bank with threshold, metering and limit logic
`timescale 1ns/10ps
module ptr_regs
  import ptr_pkg::*;
#(
  parameter int PW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  input wire logic trim_unlock,
  input wire logic ovp_cmp_raw,
  input wire logic [7:0] line_input_voltage,
  input wire logic [7:0] input_power,
  input wire logic [PW-1:0] meter_power_raw,
  input wire logic [PW-1:0] current_limit_reference,
  input wire logic [7:0] voltage_loop_value,
  output logic [20:0] overvoltage_rise_uv,
  output logic [20:0] overvoltage_fall_uv,
  output logic overvoltage_tripped,
  output logic low_power_mode,
  output logic [PW-1:0] meter_power_trimmed,
  output logic high_line_set,
  output logic [PW-1:0] current_limit_trimmed
);
  import ptr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic rst_s1;
  logic rst_sync_n;
  logic ovp_s1;
  logic ovp_s2;
  logic unlock_s1;
  logic unlock_s2;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  // comparator output and unlock level arrive from outside this clock
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ovp_s1 <= 1'b0;
      ovp_s2 <= 1'b0;
      unlock_s1 <= 1'b0;
      unlock_s2 <= 1'b0;
    end
    else
    begin
      ovp_s1 <= ovp_cmp_raw;
      ovp_s2 <= ovp_s1;
      unlock_s1 <= trim_unlock;
      unlock_s2 <= unlock_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] ov_rise;
  logic [7:0] ov_fall;
  logic [7:0] ov_deb;
  logic [7:0] lp_entry;
  logic [7:0] ofs_trim;
  logic [7:0] gain_trim;
  logic [7:0] high_line;
  logic [7:0] low_line;
  logic [7:0] current_limit_reference_adj;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
    hit = (a == ref_a);
  endfunction

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ov_rise <= RST_REG;
      ov_fall <= RST_REG;
      ov_deb <= RST_REG;
      lp_entry <= RST_REG;
      ofs_trim <= RST_REG;
      gain_trim <= RST_REG;
      high_line <= RST_REG;
      low_line <= RST_REG;
      current_limit_reference_adj <= RST_REG;
    end
    else if (reg_wr)
    begin
      if (hit(reg_addr, ADDR_OV_RISE))
        ov_rise <= reg_wdata & MASK_OV_LEVEL;
      if (hit(reg_addr, ADDR_OV_FALL))
        ov_fall <= reg_wdata & MASK_OV_LEVEL;
      if (hit(reg_addr, ADDR_OV_DEB))
        ov_deb <= reg_wdata & MASK_OV_DEB;
      if (hit(reg_addr, ADDR_LP_ENTRY))
        lp_entry <= reg_wdata & MASK_FULL;
      if (hit(reg_addr, ADDR_OFS_TRIM))
        ofs_trim <= reg_wdata & MASK_FULL;
      if (hit(reg_addr, ADDR_GAIN_TRIM))
        gain_trim <= reg_wdata & MASK_FULL;
      if (hit(reg_addr, ADDR_HIGH_LINE))
        high_line <= reg_wdata & MASK_FULL;
      if (hit(reg_addr, ADDR_LOW_LINE))
        low_line <= reg_wdata & MASK_FULL;
      if (hit(reg_addr, ADDR_CURRENT_LIMIT_REFERENCE_ADJ) && unlock_s2)
        current_limit_reference_adj <= reg_wdata & MASK_CURRENT_LIMIT_REFERENCE_ADJ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path; writes to the loop output address fall through silently
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      reg_rdata <= 8'h00;
      reg_ack <= 1'b0;
    end
    else
    begin
      reg_ack <= reg_rd | reg_wr;
      if (reg_rd)
      begin
        case (reg_addr)
          ADDR_OV_RISE: reg_rdata <= ov_rise;
          ADDR_OV_FALL: reg_rdata <= ov_fall;
          ADDR_OV_DEB: reg_rdata <= ov_deb;
          ADDR_LP_ENTRY: reg_rdata <= lp_entry;
          ADDR_OFS_TRIM: reg_rdata <= ofs_trim;
          ADDR_GAIN_TRIM: reg_rdata <= gain_trim;
          ADDR_HIGH_LINE: reg_rdata <= high_line;
          ADDR_LOW_LINE: reg_rdata <= low_line;
          ADDR_CURRENT_LIMIT_REFERENCE_ADJ: reg_rdata <= current_limit_reference_adj;
          ADDR_VLOOP: reg_rdata <= voltage_loop_value;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overvoltage thresholds in microvolts
  function automatic logic [20:0] ov_level(input logic [6:0] code);
    logic [31:0] uv;
    uv = OV_BASE_UV + (32'(code) * OV_SPAN_UV) / OV_CODES;
    ov_level = uv[20:0];
  endfunction

  // integer division truncates each level to whole microvolts; levels above 1.048 V need 21 bits
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      overvoltage_rise_uv <= 21'h000000;
      overvoltage_fall_uv <= 21'h000000;
    end
    else
    begin
      overvoltage_rise_uv <= ov_level(ov_rise[6:0]);
      overvoltage_fall_uv <= ov_level(ov_fall[6:0]);
    end
  end

  ptr_debounce u_deb (
    .clk(clk),
    .rst_n(rst_sync_n),
    .sel(ov_deb[1:0]),
    .raw(ovp_s2),
    .level(overvoltage_tripped)
  );

  ////////////////////////////////////////////////////////////////////////////
  // low power mode and line coefficient selection
  ptr_coef_e coef;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      low_power_mode <= 1'b0;
    else
      low_power_mode <= (input_power < lp_entry);
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      coef <= PTR_LOW_SET;
    else if (line_input_voltage > high_line)
      coef <= PTR_HIGH_SET;
    else if (line_input_voltage < low_line)
      coef <= PTR_LOW_SET;
    // in between the previous set is held
  end

  assign high_line_set = (coef == PTR_HIGH_SET);

  ////////////////////////////////////////////////////////////////////////////
  // power meter trims apply only while the low line set is active
  logic [PW-1:0] after_ofs;
  logic [PW-1:0] after_gain;
  logic [PW-1:0] full_scale;

  assign full_scale = {PW{1'b1}};

  // offset is a fraction of full scale; subtracting keeps the full-scale word from saturating
  ptr_trim #(.W(PW), .MAG_W(7), .SHIFT(TRIM_DIV_LOG2)) u_ofs (
    .clk(clk),
    .rst_n(rst_sync_n),
    .base(full_scale),
    .negative(1'b1),
    .mag(ofs_trim[6:0]),
    .result(after_ofs)
  );

  ptr_trim #(.W(PW), .MAG_W(7), .SHIFT(TRIM_DIV_LOG2)) u_gain (
    .clk(clk),
    .rst_n(rst_sync_n),
    .base(meter_power_raw),
    .negative(gain_trim[SIGN_BIT]),
    .mag(gain_trim[6:0]),
    .result(after_gain)
  );

  logic [PW-1:0] ofs_delta;
  logic [PW:0] meter_sum;

  always_comb
  begin
    ofs_delta = full_scale - after_ofs;
    if (ofs_trim[SIGN_BIT])
      meter_sum = (after_gain >= ofs_delta) ? {1'b0, after_gain - ofs_delta} : '0;
    else
      meter_sum = {1'b0, after_gain} + {1'b0, ofs_delta};
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      meter_power_trimmed <= '0;
    else if (coef == PTR_LOW_SET)
      meter_power_trimmed <= meter_sum[PW] ? full_scale : meter_sum[PW-1:0];
    else
      meter_power_trimmed <= meter_power_raw;
  end

  ////////////////////////////////////////////////////////////////////////////
  // current limit reference trim
  ptr_trim #(.W(PW), .MAG_W(4), .SHIFT(CURRENT_LIMIT_REFERENCE_DIV_LOG2)) u_current_limit_reference (
    .clk(clk),
    .rst_n(rst_sync_n),
    .base(current_limit_reference),
    .negative(~current_limit_reference_adj[CURRENT_LIMIT_REFERENCE_DIR_BIT]),
    .mag(current_limit_reference_adj[3:0]),
    .result(current_limit_trimmed)
  );
endmodule

// file: bench/ptr_host.sv
// host model that issues register accesses and holds the unlock level
`timescale 1ns/10ps
module ptr_host (
  input wire logic clk,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata,
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  output logic trim_unlock
);
  int n_noack = 0;
  initial
  begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    trim_unlock = 1'b0;
  end
  task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
    q = reg_rdata;
    if (reg_ack !== 1'b1)
      n_noack++;
    // released lines show the inverse, so a stale value never passes for data
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // unlock is raised before a trim write and dropped afterwards
  task automatic set_unlock(input logic v);
    @(posedge clk);
    trim_unlock <= v;
  endtask
endmodule

// file: bench/ptr_regs_chk.sv
// concurrent checks on the register bank ports
`timescale 1ns/10ps
module ptr_regs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic trim_unlock,
  input wire logic [7:0] voltage_loop_value,
  input wire logic [20:0] overvoltage_rise_uv,
  input wire logic [20:0] overvoltage_fall_uv,
  input wire logic overvoltage_tripped,
  input wire logic high_line_set
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic acc = reg_wr | reg_rd;
  chk_ack_per_access: assert property (acc |=> reg_ack)
    else $error("access not acknowledged");
  chk_ack_no_spurious: assert property (!acc |=> !reg_ack)
    else $error("acknowledge without access");
  chk_vloop_read_live: assert property (reg_rd && reg_addr == 16'hfe38
    |=> reg_rdata == $past(voltage_loop_value)) else $error("voltage loop read wrong");
  chk_ov_rsvd_zero: assert property (reg_rd && (reg_addr == 16'hfe2f || reg_addr == 16'hfe30)
    |=> !reg_rdata[7]) else $error("level reserved bit set");
  chk_deb_rsvd_zero: assert property (reg_rd && reg_addr == 16'hfe31
    |=> reg_rdata[7:2] == 6'h00) else $error("debounce reserved bits set");
  chk_trim_rsvd_zero: assert property (reg_rd && reg_addr == 16'hfe37
    |=> reg_rdata[7:5] == 3'h0) else $error("trim reserved bits set");
  chk_rise_base_level: assert property (reg_wr && reg_addr == 16'hfe2f && reg_wdata[6:0] == 7'h00
    |=> ##1 overvoltage_rise_uv == 21'd1000000) else $error("rise base level wrong");
  chk_fall_base_level: assert property (reg_wr && reg_addr == 16'hfe30 && reg_wdata[6:0] == 7'h00
    |=> ##1 overvoltage_fall_uv == 21'd1000000) else $error("fall base level wrong");
  chk_rise_write_only: assert property ($changed(overvoltage_rise_uv) && $past(overvoltage_rise_uv) != 21'h0
    |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 16'hfe2f) else $error("rise level changed unasked");
  cov_trip: cover property ($rose(overvoltage_tripped));
  cov_high_set: cover property ($rose(high_line_set));
  cov_locked_write: cover property (reg_wr && reg_addr == 16'hfe37 && !trim_unlock);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ptr_regs ptr_regs_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .trim_unlock(trim_unlock),
  .voltage_loop_value(voltage_loop_value), .overvoltage_rise_uv(overvoltage_rise_uv),
  .overvoltage_fall_uv(overvoltage_fall_uv), .overvoltage_tripped(overvoltage_tripped),
  .high_line_set(high_line_set));

// file: bench/ptr_regs_tb_top.sv
// self-checking bench for the register bank
`timescale 1ns/10ps
module ptr_regs_tb_top;
  import ptr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic overvoltage_sense_input = 1'b0;
  logic [7:0] line = 8'h00;
  logic [7:0] pwr = 8'hff;
  logic [15:0] raw = 16'h4000;
  logic [15:0] ref_i = 16'h1000;
  logic [7:0] vl = 8'ha5;
  wire logic [15:0] addr;
  wire logic wr_s;
  wire logic rd_s;
  wire logic unl;
  wire logic ack;
  wire logic trip;
  wire logic lpm;
  wire logic hs;
  wire logic [7:0] wd;
  wire logic [7:0] rdat;
  wire logic [20:0] rise;
  wire logic [20:0] fall;
  wire logic [15:0] met;
  wire logic [15:0] lim;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  logic [7:0] q;
  logic [7:0] codes[4] = '{8'h00, 8'h01, 8'h40, 8'h7f};
  int dc[4] = '{DEB_CYC_0, DEB_CYC_1, DEB_CYC_2, DEB_CYC_3};
  ptr_host u_host (.clk(clk), .reg_ack(ack), .reg_rdata(rdat), .reg_addr(addr), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_wdata(wd), .trim_unlock(unl));
  ptr_regs u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr_s), .reg_rd(rd_s), .reg_wdata(wd),
    .reg_rdata(rdat), .reg_ack(ack), .trim_unlock(unl), .ovp_cmp_raw(overvoltage_sense_input), .line_input_voltage(line),
    .input_power(pwr), .meter_power_raw(raw), .current_limit_reference(ref_i), .voltage_loop_value(vl),
    .overvoltage_rise_uv(rise), .overvoltage_fall_uv(fall), .overvoltage_tripped(trip), .low_power_mode(lpm),
    .meter_power_trimmed(met), .high_line_set(hs), .current_limit_trimmed(lim));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_host.access(a, 1'b1, d, q);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    u_host.access(a, 1'b0, 8'h00, q);
    chk(q, e);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(3);
    rst_n <= 1'b1;
    tick(3);
    for (int a = 0; a < 9; a++)
      rdc(16'(ADDR_OV_RISE + a), RST_REG);
    rdc(ADDR_VLOOP, 8'ha5);
    vl <= 8'h3c;
    wr(ADDR_VLOOP, 8'hff);
    rdc(ADDR_VLOOP, 8'h3c);
    rdc(16'hfe40, 8'h00);
    foreach (codes[i])
    begin
      wr(ADDR_OV_RISE, codes[i]);
      wr(ADDR_OV_FALL, 8'h80 | (8'h7f - codes[i]));
      rdc(ADDR_OV_FALL, 8'h7f - codes[i]);
      chk(rise, 1000000 + codes[i] * 492000 / 128);
      chk(fall, 1000000 + (8'h7f - codes[i]) * 492000 / 128);
    end
    wr(ADDR_LP_ENTRY, 8'h40);
    pwr <= 8'h3f;
    tick(3);
    chk(lpm, 1'b1);
    pwr <= 8'h40;
    tick(3);
    chk(lpm, 1'b0);
    wr(ADDR_HIGH_LINE, 8'h80);
    wr(ADDR_LOW_LINE, 8'h40);
    wr(ADDR_GAIN_TRIM, 8'h81);
    tick(4);
    chk(met, 16'h3ff8);
    wr(ADDR_GAIN_TRIM, 8'h10);
    tick(4);
    chk(met, 16'h4080);
    line <= 8'h81;
    tick(4);
    chk(hs, 1'b1);
    chk(met, 16'h4000);
    line <= 8'h40;
    tick(4);
    chk(hs, 1'b1);
    line <= 8'h3f;
    tick(4);
    chk(hs, 1'b0);
    line <= 8'h80;
    tick(4);
    chk(hs, 1'b0);
    wr(ADDR_OFS_TRIM, 8'h81);
    tick(4);
    chk(met, 16'h4061);
    wr(ADDR_OFS_TRIM, 8'h01);
    tick(4);
    chk(met, 16'h409f);
    wr(ADDR_CURRENT_LIMIT_REFERENCE_ADJ, 8'h15);
    rdc(ADDR_CURRENT_LIMIT_REFERENCE_ADJ, 8'h00);
    u_host.set_unlock(1'b1);
    tick(3);
    wr(ADDR_CURRENT_LIMIT_REFERENCE_ADJ, 8'hf5);
    rdc(ADDR_CURRENT_LIMIT_REFERENCE_ADJ, 8'h15);
    tick(3);
    chk(lim, 16'h1140);
    wr(ADDR_CURRENT_LIMIT_REFERENCE_ADJ, 8'h0f);
    tick(3);
    chk(lim, 16'h0c40);
    u_host.set_unlock(1'b0);
    tick(3);
    wr(ADDR_CURRENT_LIMIT_REFERENCE_ADJ, 8'h00);
    rdc(ADDR_CURRENT_LIMIT_REFERENCE_ADJ, 8'h0f);
    foreach (dc[s])
    begin
      wr(ADDR_OV_DEB, 8'hfc | 8'(s));
      rdc(ADDR_OV_DEB, 8'(s));
      overvoltage_sense_input <= 1'b1;
      tick(dc[s] - 2);
      overvoltage_sense_input <= 1'b0;
      tick(dc[s] + 6);
      chk(trip, 1'b0);
      overvoltage_sense_input <= 1'b1;
      n = 0;
      while (trip !== 1'b1 && n < 100)
      begin
        @(posedge clk);
        n++;
      end
      chk(n >= dc[s] + 1 && n <= dc[s] + 5, 1'b1);
      overvoltage_sense_input <= 1'b0;
      tick(dc[s] + 8);
      chk(trip, 1'b0);
    end
    chk(u_host.n_noack, 0);
    finish_test();
  end
endmodule
